// File: common/press_enable_pkg.sv
package press_enable_pkg;
    // Controller clock rate in kHz (25 MHz)
    localparam int unsigned CLK_KHZ = 25000;
    // Millisecond tick period derived from the clock rate
    localparam int unsigned MS_CYCLES = CLK_KHZ;
    localparam int unsigned MS_CNT_W = 15;
    // Reset pulse limits, in milliseconds
    localparam int unsigned PULSE_MIN_SHORT_MS = 100;
    localparam int unsigned PULSE_MIN_LONG_MS = 350;
    localparam int unsigned PULSE_MAX_MS = 30000;
    localparam int unsigned PULSE_CNT_W = 16;
    // Sync stages on pin inputs
    localparam int unsigned SYNC_STAGES = 2;

    // Press enable sequencing states
    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_READY = 2'b01,
        ST_RUN = 2'b10,
        ST_HALTING = 2'b11
    } press_state_e;
endpackage

// File: design/press_enable_logic.sv
module press_enable_logic #(
    parameter int unsigned MS_CYCLES = press_enable_pkg::MS_CYCLES,
    parameter int unsigned MAX_MS = press_enable_pkg::PULSE_MAX_MS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cfg_halt_input_en,
    input wire logic cfg_restart_interlock,
    input wire logic cfg_upstroke_en,
    input wire logic cfg_start_enable_en,
    input wire logic min_reset_pulse_select,
    input wire logic start_command,
    input wire logic halt_request_in,
    input wire logic main_enable_in,
    input wire logic start_enable_in,
    input wire logic stroke_end_position,
    input wire logic upstroke_indicator,
    input wire logic reset_pulse_in,
    output logic press_enable_out,
    output logic reset_pending_out
);
    localparam int unsigned NIN = 7;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [NIN-1:0] pin_meta_reg;
    logic [NIN-1:0] pin_reg;
    logic [NIN-1:0] pin_prev_reg;
    logic [NIN-1:0] pins_raw;
    press_enable_pkg::press_state_e state_reg;
    press_enable_pkg::press_state_e state_next;
    logic halt_pend_reg;
    logic halt_pend_next;
    logic need_reset_reg;
    logic need_reset_next;
    logic pending_next;
    logic enable_next;

    // Named views of synchronised pins
    logic s_start, s_halt, s_main, s_sten, s_stroke, s_up, s_rst;
    logic start_rise, start_fall, halt_rise, stroke_rise, up_fall;
    logic halt_event, halt_allowed, start_ok, enables_high, pulse_ok;
    logic deferred_done;
    localparam int unsigned ARM_STAGES = press_enable_pkg::SYNC_STAGES + 1;
    logic [ARM_STAGES-1:0] edge_arm_reg;
    logic edges_live;

    // All checks below run on the system clock and sleep while reset is held
    default clocking chk_clk @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Edge helpers shared by the start, halt, stroke and upstroke pins; both compare against last cycle's sample
    function automatic logic rose_now(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    function automatic logic fell_now(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction

    // Reset release through two flops; assertion is still asynchronous
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // All pins come from outside, so each passes two flops first
    assign pins_raw = {reset_pulse_in, upstroke_indicator, stroke_end_position,
                       start_enable_in, main_enable_in, halt_request_in, start_command};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= '0;
            pin_reg <= '0;
            pin_prev_reg <= '0;
        end else begin
            pin_meta_reg <= pins_raw;
            pin_reg <= pin_meta_reg;
            pin_prev_reg <= pin_reg;
        end
    end

    // Edges wait until the previous-sample stage holds a real pin value;
    // otherwise a pin that idles high (stroke end at top) shows a false edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            edge_arm_reg <= '0;
        end else begin
            edge_arm_reg <= {edge_arm_reg[ARM_STAGES-2:0], 1'b1};
        end
    end
    assign edges_live = edge_arm_reg[ARM_STAGES-1];

    assign s_start = pin_reg[0];
    assign s_halt = pin_reg[1];
    assign s_main = pin_reg[2];
    assign s_sten = pin_reg[3];
    assign s_stroke = pin_reg[4];
    assign s_up = pin_reg[5];
    assign s_rst = pin_reg[6];

    // Edges compare this cycle with the last one, once the pipeline is primed
    assign start_rise = edges_live & rose_now(s_start, pin_prev_reg[0]);
    assign start_fall = edges_live & fell_now(s_start, pin_prev_reg[0]);
    assign halt_rise = edges_live & rose_now(s_halt, pin_prev_reg[1]);
    assign stroke_rise = edges_live & rose_now(s_stroke, pin_prev_reg[4]);
    assign up_fall = edges_live & fell_now(s_up, pin_prev_reg[5]);

    // Halt source chosen by configuration; unused inputs are ignored
    assign halt_event = cfg_halt_input_en ? halt_rise : start_fall;
    // Optional inputs count as satisfied when not configured
    assign halt_allowed = ~cfg_halt_input_en | ~s_halt;
    assign enables_high = s_main & (~cfg_start_enable_en | s_sten);
    assign start_ok = start_rise & enables_high & halt_allowed & ~need_reset_reg;

    // Deferred halt completes on stroke end, or upstroke fall when configured
    assign deferred_done = stroke_rise | (cfg_upstroke_en & up_fall);

    // Reset pulse width measurement lives in a child block
    reset_pulse_checker #(
        .MS_CYCLES(MS_CYCLES),
        .MAX_MS(MAX_MS)
    ) u_pulse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pulse_in(s_rst),
        .long_min(min_reset_pulse_select),
        .valid_pulse(pulse_ok)
    );

    // Main sequencing of the enable
    always_comb begin
        state_next = state_reg;
        halt_pend_next = halt_pend_reg;
        need_reset_next = need_reset_reg;
        unique case (state_reg)
            press_enable_pkg::ST_LOCKED, press_enable_pkg::ST_READY: begin
                halt_pend_next = 1'b0;
                if (need_reset_reg && cfg_restart_interlock && pulse_ok) begin
                    need_reset_next = 1'b0;
                end
                if (!cfg_restart_interlock) begin
                    need_reset_next = 1'b0;
                end
                if (start_ok) begin
                    state_next = press_enable_pkg::ST_RUN;
                end
            end
            press_enable_pkg::ST_RUN: begin
                if (halt_event) begin
                    if (cfg_upstroke_en && !s_up) begin
                        state_next = press_enable_pkg::ST_READY;
                        need_reset_next = cfg_restart_interlock;
                    end else begin
                        state_next = press_enable_pkg::ST_HALTING;
                        halt_pend_next = 1'b1;
                    end
                end
            end
            press_enable_pkg::ST_HALTING: begin
                if (deferred_done) begin
                    state_next = press_enable_pkg::ST_READY;
                    need_reset_next = cfg_restart_interlock;
                    halt_pend_next = 1'b0;
                end
            end
        endcase
        // Safety release overrides everything
        if (!s_main && (state_next == press_enable_pkg::ST_RUN || state_next == press_enable_pkg::ST_HALTING)) begin
            state_next = press_enable_pkg::ST_READY;
            halt_pend_next = 1'b0;
            need_reset_next = cfg_restart_interlock;
        end
    end

    // Outputs registered; pending shown only once enables reach start state
    assign enable_next = (state_next == press_enable_pkg::ST_RUN) || (state_next == press_enable_pkg::ST_HALTING);
    assign pending_next = need_reset_next & cfg_restart_interlock & enables_high & ~enable_next;

    // Control state; block start needs a reset when interlock is on
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= press_enable_pkg::ST_LOCKED;
            halt_pend_reg <= 1'b0;
            need_reset_reg <= 1'b1;
            press_enable_out <= 1'b0;
            reset_pending_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            halt_pend_reg <= halt_pend_next;
            need_reset_reg <= need_reset_next;
            press_enable_out <= enable_next;
            reset_pending_out <= pending_next;
        end
    end

    // Safety release and the relation between the two outputs
    chk_main_low_drops: assert property (
        !s_main |=> !press_enable_out)
        else $error("enable high with main low");

    chk_outputs_exclusive: assert property (
        !(press_enable_out && reset_pending_out))
        else $error("enable and pending both high");

    chk_main_low_pending: assert property (
        !s_main |=> !reset_pending_out)
        else $error("pending shown with main low");

    chk_pending_needs_enables: assert property (
        reset_pending_out |-> $past(enables_high))
        else $error("pending shown before start state");

    chk_pending_off_free: assert property (
        !cfg_restart_interlock |-> !reset_pending_out)
        else $error("pending without interlock");

    chk_enable_tracks_state: assert property (
        press_enable_out == (state_reg == press_enable_pkg::ST_RUN || state_reg == press_enable_pkg::ST_HALTING))
        else $error("enable disagrees with state");

    // Starting the press
    chk_interlock_blocks: assert property (
        (cfg_restart_interlock && need_reset_reg && !pulse_ok && state_reg != press_enable_pkg::ST_RUN
         && state_reg != press_enable_pkg::ST_HALTING) |=> !press_enable_out)
        else $error("enable rose without reset");

    chk_start_rises: assert property (
        (start_ok && !press_enable_out) |=> press_enable_out)
        else $error("valid start ignored");

    chk_rise_needs_start: assert property (
        (!press_enable_out ##1 press_enable_out) |-> $past(start_rise))
        else $error("enable rose without start");

    chk_halt_blocks_start: assert property (
        (!press_enable_out && cfg_halt_input_en && s_halt) |=> !press_enable_out)
        else $error("start taken with halt high");

    chk_sten_gates_rise: assert property (
        (!press_enable_out && cfg_start_enable_en && !s_sten) |=> !press_enable_out)
        else $error("start taken with second enable low");

    chk_sten_unwatched: assert property (
        (state_reg == press_enable_pkg::ST_RUN && !halt_event && s_main) |=> press_enable_out)
        else $error("running enable dropped without halt");

    // Which event counts as a halt request
    chk_start_fall_halts: assert property (
        (state_reg == press_enable_pkg::ST_RUN && !cfg_halt_input_en && start_fall)
        |=> state_reg != press_enable_pkg::ST_RUN)
        else $error("start fall did not halt");

    chk_halt_source: assert property (
        (state_reg == press_enable_pkg::ST_RUN && cfg_halt_input_en && start_fall && !halt_rise && s_main)
        |=> press_enable_out)
        else $error("start fall halted with halt option");

    chk_halt_rise_halts: assert property (
        (state_reg == press_enable_pkg::ST_RUN && cfg_halt_input_en && halt_rise)
        |=> state_reg != press_enable_pkg::ST_RUN)
        else $error("halt input edge ignored");

    chk_halt_pin_ignored: assert property (
        (state_reg == press_enable_pkg::ST_RUN && !cfg_halt_input_en && halt_rise && !start_fall && s_main)
        |=> press_enable_out)
        else $error("unused halt input acted");

    // Immediate halts outside the upstroke when the upstroke input is enabled, deferred ones otherwise
    chk_fast_halt: assert property (
        (state_reg == press_enable_pkg::ST_RUN && halt_event && cfg_upstroke_en && !s_up) |=> !press_enable_out)
        else $error("halt with upstroke low not immediate");

    chk_fast_halt_pending: assert property (
        (state_reg == press_enable_pkg::ST_RUN && halt_event && cfg_upstroke_en && !s_up && enables_high)
        |=> reset_pending_out == cfg_restart_interlock)
        else $error("pending wrong after immediate halt");

    chk_deferred_entry: assert property (
        (state_reg == press_enable_pkg::ST_RUN && halt_event && cfg_upstroke_en && s_up && s_main)
        |=> state_reg == press_enable_pkg::ST_HALTING)
        else $error("upstroke halt not deferred");

    chk_deferred_hold: assert property (
        (state_reg == press_enable_pkg::ST_HALTING && !deferred_done && s_main) |=> press_enable_out)
        else $error("deferred halt dropped early");

    chk_upstroke_fall_ends: assert property (
        (state_reg == press_enable_pkg::ST_HALTING && cfg_upstroke_en && up_fall) |=> !press_enable_out)
        else $error("upstroke fall did not end halt");

    chk_deferred_pending: assert property (
        (state_reg == press_enable_pkg::ST_HALTING && deferred_done && enables_high)
        |=> reset_pending_out == cfg_restart_interlock)
        else $error("pending wrong after deferred halt");

    chk_no_upstroke_defer: assert property (
        (state_reg == press_enable_pkg::ST_RUN && halt_event && !cfg_upstroke_en && s_main) |=> press_enable_out)
        else $error("halt acted before stroke end");

    chk_upfall_unused: assert property (
        (state_reg == press_enable_pkg::ST_HALTING && !cfg_upstroke_en && up_fall && !stroke_rise && s_main)
        |=> press_enable_out)
        else $error("unused upstroke input ended halt");

    chk_stroke_halt: assert property (
        (state_reg == press_enable_pkg::ST_HALTING && stroke_rise)
        |=> !press_enable_out ##0 (need_reset_reg == cfg_restart_interlock))
        else $error("stroke end halt wrong");

    chk_pend_tracks_halting: assert property (
        halt_pend_reg == (state_reg == press_enable_pkg::ST_HALTING))
        else $error("pending halt flag lost");

    // Restart interlock bookkeeping
    chk_pending_holds: assert property (
        (cfg_restart_interlock && need_reset_reg && !pulse_ok) |=> need_reset_reg)
        else $error("restart need cleared without pulse");

    chk_pulse_clears: assert property (
        (cfg_restart_interlock && pulse_ok && !press_enable_out) |=> !need_reset_reg)
        else $error("valid pulse did not clear restart need");

    chk_pending_needs_lock: assert property (
        reset_pending_out |-> need_reset_reg)
        else $error("pending shown with no restart need");

    // Edge pipeline
    chk_edge_armed: assert property (
        (start_rise || start_fall || halt_rise || stroke_rise || up_fall) |-> edges_live)
        else $error("edge seen before pipeline primed");

    chk_sync_delay: assert property (
        1'b1 |=> pin_prev_reg == $past(pin_reg))
        else $error("edge compare not one cycle back");
endmodule

// File: design/reset_pulse_checker.sv
// Measures the high phase of the reset pulse in milliseconds and flags valid
// low-high-low sequences.
module reset_pulse_checker #(
    parameter int unsigned MS_CYCLES = press_enable_pkg::MS_CYCLES,
    parameter int unsigned MAX_MS = press_enable_pkg::PULSE_MAX_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pulse_in,
    input wire logic long_min,
    output logic valid_pulse
);
    logic [press_enable_pkg::MS_CNT_W-1:0] div_reg;
    logic [press_enable_pkg::PULSE_CNT_W-1:0] width_reg;
    logic pulse_prev_reg;
    logic armed_reg;
    logic ms_tick;
    logic fall;
    logic rise;
    logic [press_enable_pkg::PULSE_CNT_W-1:0] min_ms;
    logic width_ok;

    // Millisecond tick restarts on each rising edge so widths are exact to 1 ms
    assign ms_tick = (div_reg == press_enable_pkg::MS_CNT_W'(MS_CYCLES - 1));
    assign rise = pulse_in & ~pulse_prev_reg;
    assign fall = ~pulse_in & pulse_prev_reg;
    assign min_ms = long_min ? press_enable_pkg::PULSE_CNT_W'(press_enable_pkg::PULSE_MIN_LONG_MS)
                             : press_enable_pkg::PULSE_CNT_W'(press_enable_pkg::PULSE_MIN_SHORT_MS);
    assign width_ok = (width_reg >= min_ms) && (width_reg <= press_enable_pkg::PULSE_CNT_W'(MAX_MS));

    // Width counter saturates just above the limit so long pulses stay rejected
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            width_reg <= '0;
            pulse_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            valid_pulse <= 1'b0;
        end else begin
            pulse_prev_reg <= pulse_in;
            valid_pulse <= fall & armed_reg & width_ok;
            if (rise) begin
                // The rise cycle is already the first high cycle; needs MS_CYCLES of 2 or more
                div_reg <= press_enable_pkg::MS_CNT_W'(1);
                width_reg <= '0;
                armed_reg <= 1'b1;
            end else if (pulse_in) begin
                div_reg <= ms_tick ? '0 : div_reg + 1'b1;
                if (ms_tick && width_reg <= press_enable_pkg::PULSE_CNT_W'(MAX_MS)) begin
                    width_reg <= width_reg + 1'b1;
                end
            end else begin
                armed_reg <= 1'b0;
            end
        end
    end

    chk_short_pulse_rejected: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fall && width_reg < min_ms) |=> !valid_pulse)
        else $error("short pulse accepted");
    chk_long_pulse_rejected: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fall && width_reg > press_enable_pkg::PULSE_CNT_W'(MAX_MS)) |=> !valid_pulse)
        else $error("long pulse accepted");
    chk_good_pulse_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fall && armed_reg && width_ok) |=> valid_pulse)
        else $error("valid pulse lost");
endmodule

// File: verification/press_automatic_enable_logic_test.sv
module press_automatic_enable_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 4;
    // Short ceiling keeps the over-long pulse case inside the run budget
    localparam int MAXMS = 500;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] cfg = 5'h00; // halt input, interlock, upstroke, second enable, long minimum
    logic start_command = 1'b0;
    logic halt_request_in = 1'b0;
    logic main_enable_in = 1'b0;
    logic start_enable_in = 1'b0;
    logic pulse_go = 1'b0;
    logic stroke_go = 1'b0;
    logic [31:0] pulse_len = 32'h0;
    logic busy, reset_pulse_in, stroke_end_position, upstroke_indicator, press_enable_out, reset_pending_out;
    int err_count = 0;
    int n_checks = 0;
    always #20 clk_sys = ~clk_sys;

    press_enable_logic #(.MS_CYCLES(MSC), .MAX_MS(MAXMS)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .cfg_halt_input_en(cfg[4]), .cfg_restart_interlock(cfg[3]),
        .cfg_upstroke_en(cfg[2]), .cfg_start_enable_en(cfg[1]), .min_reset_pulse_select(cfg[0]),
        .start_command(start_command), .halt_request_in(halt_request_in), .main_enable_in(main_enable_in),
        .start_enable_in(start_enable_in), .stroke_end_position(stroke_end_position),
        .upstroke_indicator(upstroke_indicator), .reset_pulse_in(reset_pulse_in),
        .press_enable_out(press_enable_out), .reset_pending_out(reset_pending_out));
    press_partner_model u_far (
        .clk_sys(clk_sys), .pulse_go(pulse_go), .pulse_len(pulse_len), .stroke_go(stroke_go), .busy(busy),
        .reset_pulse_in(reset_pulse_in), .stroke_end_position(stroke_end_position),
        .upstroke_indicator(upstroke_indicator));

    function automatic logic pulse_ok(input int ms, input logic long_min);
        int lo;
        lo = long_min ? press_enable_pkg::PULSE_MIN_LONG_MS : press_enable_pkg::PULSE_MIN_SHORT_MS;
        return (ms >= lo) && (ms <= MAXMS);
    endfunction
    task automatic check(input logic seen, input logic exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: saw %b expected %b", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic restart(input logic [4:0] c);
        arst_n = 1'b0;
        cfg = c;
        {start_command, halt_request_in, main_enable_in, start_enable_in} = 4'h0;
        cyc(5);
        arst_n = 1'b1;
        cyc(6);
    endtask
    // Holding the request two edges means the partner cannot miss it
    task automatic wait_idle;
        for (int k = 0; k < 5000 && busy; k++) cyc(1);
        cyc(4);
    endtask
    task automatic pulse(input int ms);
        pulse_len = ms * MSC;
        pulse_go = 1'b1;
        cyc(2);
        pulse_go = 1'b0;
        wait_idle();
    endtask
    task automatic stroke;
        stroke_go = 1'b1;
        cyc(2);
        stroke_go = 1'b0;
    endtask
    task automatic set_start(input logic v);
        start_command = v;
        cyc(4);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(negedge clk_sys);
        err_count++;
        results();
    end

    initial begin
        int ms;
        void'($urandom(32'h9c3d));
        // Restart pulse width window, both minimum settings
        for (int lm = 0; lm < 2; lm++) begin
            restart({4'b0100, lm[0]});
            check(reset_pending_out, 1'b0, "pending before start state");
            main_enable_in = 1'b1;
            cyc(4);
            check(reset_pending_out, 1'b1, "pending at first start");
            set_start(1'b1);
            check(press_enable_out, 1'b0, "start without restart");
            set_start(1'b0);
            // Random widths plus exact corners just under the minimum and just over the ceiling
            for (int i = 0; i < 5; i++) begin
                if (i == 0) ms = lm ? 110 + $urandom % 230 : 10 + $urandom % 85;
                else if (i == 1) ms = 510 + $urandom % 300;
                else if (i == 2) ms = lm ? press_enable_pkg::PULSE_MIN_LONG_MS - 1 : press_enable_pkg::PULSE_MIN_SHORT_MS - 1;
                else if (i == 3) ms = MAXMS + 1;
                else ms = lm ? 352 + $urandom % 140 : press_enable_pkg::PULSE_MIN_SHORT_MS;
                pulse(ms);
                check(reset_pending_out, !pulse_ok(ms, lm[0]), "pulse width judgement");
            end
            set_start(1'b1);
            check(press_enable_out, 1'b1, "start after restart");
            check(reset_pending_out, 1'b0, "pending while enabled");
            main_enable_in = 1'b0;
            cyc(4);
            check(press_enable_out, 1'b0, "main enable dropped");
            main_enable_in = 1'b1;
            cyc(4);
            check(reset_pending_out, 1'b1, "pending after drop");
        end
        // Halt from start falling edge, no upstroke input
        restart(5'b00000);
        main_enable_in = 1'b1;
        set_start(1'b1);
        check(press_enable_out, 1'b1, "start without second enable");
        set_start(1'b0);
        check(press_enable_out, 1'b1, "halt waits for top");
        stroke();
        wait_idle();
        check(press_enable_out, 1'b0, "halt at top");
        check(reset_pending_out, 1'b0, "no pending without interlock");
        // Dedicated halt input with upstroke input
        restart(5'b11100);
        main_enable_in = 1'b1;
        pulse(150);
        halt_request_in = 1'b1;
        set_start(1'b1);
        check(press_enable_out, 1'b0, "start with halt high");
        halt_request_in = 1'b0;
        set_start(1'b0);
        set_start(1'b1);
        set_start(1'b0);
        check(press_enable_out, 1'b1, "start fall ignored");
        halt_request_in = 1'b1;
        cyc(4);
        check(press_enable_out, 1'b0, "halt outside upstroke");
        halt_request_in = 1'b0;
        pulse(150);
        set_start(1'b1);
        stroke();
        cyc(4);
        halt_request_in = 1'b1;
        cyc(4);
        check(press_enable_out, 1'b1, "halt held in upstroke");
        wait_idle();
        check(press_enable_out, 1'b0, "deferred halt at top");
        check(reset_pending_out, 1'b1, "pending after deferred halt");
        // Second enable only gates the rising of the enable
        restart(5'b00010);
        main_enable_in = 1'b1;
        set_start(1'b1);
        check(press_enable_out, 1'b0, "second enable low");
        set_start(1'b0);
        start_enable_in = 1'b1;
        set_start(1'b1);
        check(press_enable_out, 1'b1, "second enable high");
        start_enable_in = 1'b0;
        cyc(4);
        check(press_enable_out, 1'b1, "second enable unwatched");
        results();
    end
endmodule

// File: verification/press_partner_model.sv
// Stand-in for the contact monitor and the PLC: makes restart pulses and strokes
module press_partner_model #(
    parameter int STROKE = 24
) (
    input wire logic clk_sys,
    input wire logic pulse_go,
    input wire logic [31:0] pulse_len,
    input wire logic stroke_go,
    output logic busy,
    output logic reset_pulse_in = 1'b0,
    output logic stroke_end_position = 1'b1,
    output logic upstroke_indicator = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int pcnt = 0;
    int scnt = 0;
    assign busy = (pcnt != 0) || (scnt != 0);
    // Low-high-low restart pulse, high for exactly pulse_len cycles
    always @(negedge clk_sys) begin
        if (pcnt != 0) begin
            pcnt <= pcnt - 1;
            reset_pulse_in <= (pcnt > 1);
        end else if (pulse_go) begin
            pcnt <= pulse_len;
            reset_pulse_in <= 1'b1;
        end
    end
    // Stroke leaves top on the upstroke, then top is reached again
    always @(negedge clk_sys) begin
        if (scnt != 0) begin
            scnt <= scnt - 1;
            stroke_end_position <= (scnt == 1);
            upstroke_indicator <= (scnt != 1);
        end else if (stroke_go) begin
            scnt <= STROKE;
            stroke_end_position <= 1'b0;
            upstroke_indicator <= 1'b1;
        end
    end
endmodule
